// ---- logic/gpio_alt_function_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_alt_function_select #(
   parameter int ADDR_W = 12
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Core side sources
   input wire logic [53:0] gpio_out_i,
   input wire logic [53:0] gpio_oe_i,
   input wire logic [53:0] alt_source_zero_out_i,
   input wire logic [53:0] alt_source_zero_oe_i,
   input wire logic [53:0] alt_source_one_out_i,
   input wire logic [53:0] alt_source_one_oe_i,
   // Pad side
   input wire logic [53:0] pad_in_i,
   output logic [53:0] pad_out_o,
   output logic [53:0] pad_oe_o,
   // Pad input steered back to its owner
   output logic [53:0] gpio_in_o,
   output logic [53:0] alt_source_zero_in_o,
   output logic [53:0] alt_source_one_in_o,
   // Current function-enable state
   output logic [53:0] pin_function_enable_o
);

   // Elaboration checks
   if (ADDR_W < pin_mux_pkg::ADDR_DEC_W) begin : g_addr_chk
      $error("ADDR_W too narrow for the register offsets");
   end
   if (pin_mux_pkg::LOW_PINS + pin_mux_pkg::HIGH_BITS
       != pin_mux_pkg::NUM_PINS) begin : g_pin_chk
      $error("Pin count does not match register layout");
   end

   // Byte-lane merge of a write
   function automatic logic [31:0] merge_strobe(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0] strb
   );
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_val[8*b +: 8];
         end
      end
      return res;
   endfunction : merge_strobe

   // Route of one pin from its enable bit and selector code
   function automatic pin_mux_pkg::route_type pick_route(
      input logic enable,
      input logic [1:0] code
   );
      pin_mux_pkg::route_type r;
      r = pin_mux_pkg::ROUTE_GPIO;
      if (enable) begin
         case (code)
            pin_mux_pkg::SEL_SOURCE_ZERO: r = pin_mux_pkg::ROUTE_ALT_ZERO;
            pin_mux_pkg::SEL_SOURCE_ONE: r = pin_mux_pkg::ROUTE_ALT_ONE;
            default: r = pin_mux_pkg::ROUTE_NONE;
         endcase
      end
      return r;
   endfunction : pick_route

   logic [31:0] pin_function_low_ff;
   logic [21:0] pin_function_high_ff;
   logic [31:0] alt_choice_ff;
   logic [53:0] pad_meta_ff;
   logic [53:0] pad_sync_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [53:0] pad_out_ff;
   logic [53:0] pad_oe_ff;
   logic [53:0] gpio_in_ff;
   logic [53:0] alt_zero_in_ff;
   logic [53:0] alt_one_in_ff;
   logic [53:0] enables;
   logic setup_phase;
   logic wr_take;
   logic hit_low;
   logic hit_high;
   logic hit_sel;
   logic [31:0] nxt_prdata;
   logic nxt_pslverr;
   logic [53:0] nxt_pad_out;
   logic [53:0] nxt_pad_oe;
   logic [53:0] nxt_gpio_in;
   logic [53:0] nxt_alt_zero_in;
   logic [53:0] nxt_alt_one_in;
   logic [11:0] dec_addr;
   logic [31:0] high_merged;

   assign enables = {pin_function_high_ff, pin_function_low_ff};

   // Strobe merge of the high register, cut back to its 22 live bits
   assign high_merged = merge_strobe({10'h000, pin_function_high_ff},
      pwdata_i, pstrb_i);

   // Address decode and transfer phases
   assign dec_addr = paddr_i[pin_mux_pkg::ADDR_DEC_W-1:0];
   assign setup_phase = psel_i && !penable_i;
   assign wr_take = psel_i && penable_i && pready_ff && pwrite_i;
   assign hit_low = dec_addr == pin_mux_pkg::PIN_FUNCTION_LOW_OFS;
   assign hit_high = dec_addr == pin_mux_pkg::PIN_FUNCTION_HIGH_OFS;
   assign hit_sel = dec_addr == pin_mux_pkg::ALT_CHOICE_OFS;

   // Read data and error, prepared in setup
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      if (hit_low) begin
         nxt_prdata = pin_function_low_ff;
      end else if (hit_high) begin
         nxt_prdata = {10'h000, pin_function_high_ff};
      end else if (hit_sel) begin
         nxt_prdata = alt_choice_ff;
      end else begin
         nxt_pslverr = 1'b1;
      end
      if (pwrite_i) begin
         nxt_prdata = 32'h0000_0000;
      end
   end

   // APB answer, one wait-free access cycle
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= setup_phase;
         if (setup_phase) begin
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
         end
      end
   end

   // Low function-enable register
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pin_function_low_ff <= pin_mux_pkg::PIN_FUNCTION_LOW_RST;
      end else if (wr_take && hit_low) begin
         pin_function_low_ff <= merge_strobe(pin_function_low_ff,
            pwdata_i, pstrb_i);
      end
   end

   // High function-enable register, upper bits dropped
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pin_function_high_ff <= pin_mux_pkg::PIN_FUNCTION_HIGH_RST;
      end else if (wr_take && hit_high) begin
         pin_function_high_ff <= high_merged[21:0];
      end
   end

   // Selector register for pins 0 to 15
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         alt_choice_ff <= pin_mux_pkg::ALT_CHOICE_RST;
      end else if (wr_take && hit_sel) begin
         alt_choice_ff <= merge_strobe(alt_choice_ff, pwdata_i,
            pstrb_i);
      end
   end

   // Two-stage synchroniser on pad inputs
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pad_meta_ff <= '0;
         pad_sync_ff <= '0;
      end else begin
         pad_meta_ff <= pad_in_i;
         pad_sync_ff <= pad_meta_ff;
      end
   end

   // Per-pin multiplexer
   always_comb begin
      pin_mux_pkg::route_type rt;
      logic [1:0] code;
      rt = pin_mux_pkg::ROUTE_GPIO;
      code = pin_mux_pkg::SEL_SOURCE_ZERO;
      nxt_pad_out = '0;
      nxt_pad_oe = '0;
      nxt_gpio_in = '0;
      nxt_alt_zero_in = '0;
      nxt_alt_one_in = '0;
      for (int p = 0; p < pin_mux_pkg::NUM_PINS; p++) begin
         // Pins above 15 have no selector here and use source zero
         code = pin_mux_pkg::SEL_SOURCE_ZERO;
         if (p < pin_mux_pkg::SEL_PINS) begin
            code = alt_choice_ff[pin_mux_pkg::SEL_W*p +: 2];
         end
         rt = pick_route(enables[p], code);
         case (rt)
            pin_mux_pkg::ROUTE_GPIO: begin
               nxt_pad_out[p] = gpio_out_i[p];
               nxt_pad_oe[p] = gpio_oe_i[p];
               nxt_gpio_in[p] = pad_sync_ff[p];
            end
            pin_mux_pkg::ROUTE_ALT_ZERO: begin
               nxt_pad_out[p] = alt_source_zero_out_i[p];
               nxt_pad_oe[p] = alt_source_zero_oe_i[p];
               nxt_alt_zero_in[p] = pad_sync_ff[p];
            end
            pin_mux_pkg::ROUTE_ALT_ONE: begin
               nxt_pad_out[p] = alt_source_one_out_i[p];
               nxt_pad_oe[p] = alt_source_one_oe_i[p];
               nxt_alt_one_in[p] = pad_sync_ff[p];
            end
            default: begin
               // Reserved code: pad left undriven
               nxt_pad_out[p] = 1'b0;
               nxt_pad_oe[p] = 1'b0;
            end
         endcase
      end
   end

   // Registered pad and owner outputs
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pad_out_ff <= '0;
         pad_oe_ff <= '0;
         gpio_in_ff <= '0;
         alt_zero_in_ff <= '0;
         alt_one_in_ff <= '0;
      end else begin
         pad_out_ff <= nxt_pad_out;
         pad_oe_ff <= nxt_pad_oe;
         gpio_in_ff <= nxt_gpio_in;
         alt_zero_in_ff <= nxt_alt_zero_in;
         alt_one_in_ff <= nxt_alt_one_in;
      end
   end

   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign pad_out_o = pad_out_ff;
   assign pad_oe_o = pad_oe_ff;
   assign gpio_in_o = gpio_in_ff;
   assign alt_source_zero_in_o = alt_zero_in_ff;
   assign alt_source_one_in_o = alt_one_in_ff;
   assign pin_function_enable_o = enables;

   // Checks
   chk_low_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      wr_take && hit_low && pstrb_i == 4'hf
      |=> pin_function_low_ff == $past(pwdata_i))
      else $error("Low enable register missed a full write");

   chk_high_read: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      setup_phase && hit_high && !pwrite_i
      |=> prdata_o[31:22] == 10'h000 && pready_o)
      else $error("Reserved high bits read as nonzero");

   chk_gpio_route: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      !enables[0] |=> pad_out_o[0] == $past(gpio_out_i[0])
      && pad_oe_o[0] == $past(gpio_oe_i[0]))
      else $error("Disabled pin 0 not driven by gpio");

   chk_alt_one: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      enables[0] && alt_choice_ff[1:0] == 2'h1
      |=> pad_out_o[0] == $past(alt_source_one_out_i[0]))
      else $error("Pin 0 not on alternate source one");

   chk_alt_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      enables[3] && alt_choice_ff[7:6] == 2'h0
      |=> pad_oe_o[3] == $past(alt_source_zero_oe_i[3]))
      else $error("Pin 3 not on alternate source zero");

   chk_sel_ignored: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      !enables[1] && alt_choice_ff[3:2] != 2'h0
      |=> pad_oe_o[1] == $past(gpio_oe_i[1])
      && alt_source_one_in_o[1] == 1'b0)
      else $error("Selector acted on a gpio pin");

   chk_field_pack: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      wr_take && hit_sel && pstrb_i[3]
      |=> alt_choice_ff[31:30] == $past(pwdata_i[31:30]))
      else $error("Pin 15 selector field misplaced");

   chk_reset_zero: assert property (@(posedge sys_clk_i)
      $past(srst_i) && !srst_i
      |-> enables == '0 && alt_choice_ff == '0)
      else $error("Registers not zero after reset");

   chk_unmapped_err: assert property (@(posedge sys_clk_i)
      disable iff (srst_i)
      setup_phase && !hit_low && !hit_high && !hit_sel
      |=> pslverr_o && pready_o ##1 !pready_o)
      else $error("Unmapped access not answered with error");

   // Main scenarios
   cov_alt_one: cover property (@(posedge sys_clk_i) disable iff (srst_i)
      enables[0] && alt_choice_ff[1:0] == 2'h1 ##1 pad_oe_o[0]);
   cov_high_write: cover property (@(posedge sys_clk_i) disable iff (srst_i)
      wr_take && hit_high);
   cov_reserved: cover property (@(posedge sys_clk_i) disable iff (srst_i)
      enables[2] && alt_choice_ff[5:4] == 2'h3);
   cov_error: cover property (@(posedge sys_clk_i) disable iff (srst_i)
      pready_o && pslverr_o);

endmodule : gpio_alt_function_select
`default_nettype wire

// ---- logic/pin_mux_pkg.sv ----
package pin_mux_pkg;
   // Register byte offsets
   localparam logic [11:0] PIN_FUNCTION_LOW_OFS = 12'ha90;
   localparam logic [11:0] PIN_FUNCTION_HIGH_OFS = 12'ha94;
   localparam logic [11:0] ALT_CHOICE_OFS = 12'ha98;
   // Pin counts and field layout
   localparam int NUM_PINS = 54;
   localparam int LOW_PINS = 32;
   localparam int HIGH_BITS = 22;
   localparam int SEL_PINS = 16;
   localparam int SEL_W = 2;
   localparam int ADDR_DEC_W = 12;
   // Reset values
   localparam logic [31:0] PIN_FUNCTION_LOW_RST = 32'h0000_0000;
   localparam logic [21:0] PIN_FUNCTION_HIGH_RST = 22'h00_0000;
   localparam logic [31:0] ALT_CHOICE_RST = 32'h0000_0000;
   // Selector codes
   localparam logic [1:0] SEL_SOURCE_ZERO = 2'h0;
   localparam logic [1:0] SEL_SOURCE_ONE = 2'h1;
   // Where a pin is routed
   typedef enum logic [1:0] {
      ROUTE_GPIO,
      ROUTE_ALT_ZERO,
      ROUTE_ALT_ONE,
      ROUTE_NONE
   } route_type;
endpackage : pin_mux_pkg

// ---- tb/gpio_alt_function_select_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_alt_function_select_tb;
   localparam logic [11:0] LO = pin_mux_pkg::PIN_FUNCTION_LOW_OFS;
   localparam logic [11:0] HI = pin_mux_pkg::PIN_FUNCTION_HIGH_OFS;
   localparam logic [11:0] SL = pin_mux_pkg::ALT_CHOICE_OFS;
   localparam logic [11:0] NOMAP = 12'ha9c;
   // Design inputs, all given a value at time zero
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [3:0] pstrb_i = 4'hf;
   logic [53:0] g_out = '0, g_oe = '0, z_out = '0, z_oe = '0;
   logic [53:0] o_out = '0, o_oe = '0, pad_in = '0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o;
   logic [53:0] pad_out_o, pad_oe_o, gpio_in_o, z_in_o, o_in_o, fen_o;
   // Bench state and reference model of the registers
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [31:0] seed = 32'haa83;
   logic [31:0] m_lo = '0, m_sel = '0, rdv;
   logic [21:0] m_hi = '0;
   logic [53:0] rv;
   logic errv;

   gpio_alt_function_select #(.ADDR_W(12)) i_gpio_alt_function_select (
      .sys_clk_i(sys_clk_i), .srst_i(srst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .gpio_out_i(g_out),
      .gpio_oe_i(g_oe), .alt_source_zero_out_i(z_out),
      .alt_source_zero_oe_i(z_oe), .alt_source_one_out_i(o_out),
      .alt_source_one_oe_i(o_oe), .pad_in_i(pad_in), .pad_out_o(pad_out_o),
      .pad_oe_o(pad_oe_o), .gpio_in_o(gpio_in_o),
      .alt_source_zero_in_o(z_in_o), .alt_source_one_in_o(o_in_o),
      .pin_function_enable_o(fen_o));

   // Clock and hang guard
   always #25 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end

   // Pseudo-random source
   function automatic logic [53:0] r54();
      logic [63:0] t;
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      t[63:32] = seed;
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      t[31:0] = seed;
      return t[53:0];
   endfunction : r54

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [63:0] e, g);
      tests_run++;
      if (e !== g) begin
         err_count++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   // One APB transfer, held until pready is sampled high at an edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= s;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
      end while (pready_o !== 1'b1);
      rdv = prdata_o;
      errv = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   // Write with byte strobes, mirrored into the model
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      apb(1'b1, a, d, s);
      chk("slverr_ok", 1'b0, errv);
      if (a == LO) m_lo = (m_lo & ~m) | (d & m);
      if (a == HI) m_hi = (m_hi & ~m[21:0]) | (d[21:0] & m[21:0]);
      if (a == SL) m_sel = (m_sel & ~m) | (d & m);
   endtask : wr

   task automatic rd_all();
      apb(1'b0, LO, 32'h0, 4'h0);
      chk("low", m_lo, rdv);
      apb(1'b0, HI, 32'h0, 4'h0);
      chk("high", {10'h0, m_hi}, rdv);
      apb(1'b0, SL, 32'h0, 4'h0);
      chk("sel", m_sel, rdv);
   endtask : rd_all

   // Pin routing compared against the model
   task automatic check_mux();
      logic [53:0] en, g, z, o;
      logic [1:0] c;
      #1;
      en = {m_hi, m_lo};
      for (int p = 0; p < 54; p++) begin
         c = (p < 16) ? m_sel[2*p +: 2] : 2'h0;
         g[p] = !en[p];
         z[p] = en[p] && c == pin_mux_pkg::SEL_SOURCE_ZERO;
         o[p] = en[p] && c == pin_mux_pkg::SEL_SOURCE_ONE;
      end
      repeat (4) @(posedge sys_clk_i);
      #1;
      chk("fen", en, fen_o);
      chk("oe", (g & g_oe) | (z & z_oe) | (o & o_oe), pad_oe_o);
      chk("out", (g & g_out) | (z & z_out) | (o & o_out),
          pad_out_o);
      chk("gin", pad_in & g, gpio_in_o);
      chk("zin", pad_in & z, z_in_o);
      chk("oin", pad_in & o, o_in_o);
   endtask : check_mux

   task automatic drive();
      @(posedge sys_clk_i);
      g_out <= r54();
      g_oe <= r54();
      z_out <= r54();
      z_oe <= r54();
      o_out <= r54();
      o_oe <= r54();
      pad_in <= r54();
   endtask : drive

   // Main sequence
   initial begin
      repeat (2) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      rd_all();
      drive();
      check_mux();
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         rv = r54();
         // Pins 0 and 3 always function-enabled, pin 1 always gpio
         wr(LO, (rv[31:0] | 32'h0000_0009) & 32'hffff_fffd, 4'hf);
         rv = r54();
         wr(HI, rv[31:0], 4'hf);
         rv = r54();
         wr(SL, (i < 4) ? {16{i[1:0]}} : rv[31:0], 4'hf);
         rd_all();
         drive();
         check_mux();
      end
      $display("test routing done");
      wr(HI, 32'hffff_ffff, 4'hf);
      wr(SL, 32'h1234_5678, 4'h5);
      rd_all();
      apb(1'b1, NOMAP, 32'hffff_ffff, 4'hf);
      chk("slverr_w", 1'b1, errv);
      apb(1'b0, NOMAP, 32'h0, 4'h0);
      chk("slverr_r", 1'b1, errv);
      chk("nomap", 32'h0, rdv);
      rd_all();
      $display("test strobes and unmapped done");
      @(posedge sys_clk_i);
      srst_i <= 1'b1;
      @(posedge sys_clk_i);
      srst_i <= 1'b0;
      m_lo = '0;
      m_hi = '0;
      m_sel = '0;
      rd_all();
      check_mux();
      $display("test second reset done");
      give_verdict();
   end
endmodule : gpio_alt_function_select_tb
`default_nettype wire
